// [rtl/cam_pkg.sv]
package cam_pkg;
   localparam int unsigned ENTRIES = 32;
   localparam int unsigned IDX_W = 5;
   localparam int unsigned TAG_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned INSTR_W = 32;
   localparam int unsigned ADDR_LSB = 0;
   localparam logic [IDX_W-1:0] PTR_RST = 5'h00;
   localparam logic [ENTRIES-1:0] VALID_RST = 32'h0000_0000;

   typedef logic [IDX_W-1:0] idx_t;
   typedef logic [TAG_W-1:0] tag_t;

   typedef struct packed {
      logic valid;
      logic [INSTR_W-1:0] instr;
   } instr_req_s;

   typedef struct packed {
      logic valid;
      logic hit;
      idx_t index;
      logic [INSTR_W-1:0] instr;
   } lookup_rsp_s;

   typedef struct packed {
      logic req;
      tag_t addr;
   } mem_req_s;

   typedef struct packed {
      logic valid;
      logic [DATA_W-1:0] data;
   } mem_rsp_s;

   typedef struct packed {
      logic we;
      idx_t index;
      logic [DATA_W-1:0] data;
   } pad_wr_s;
endpackage

// [rtl/cam_scratchpad_cache.sv]
// Overview of operation
// - next instruction word is latched before lookup; address comes from it
// - instruction address compared against all tags in parallel
// - on hit, matching scratchpad index is output without memory read
// - on miss, read main memory and write the word into a free entry
// - filled entry receives the memory address as tag and valid set
// - when no entry is free, an occupied entry is overwritten
// - 32 entries with 12-bit tags covering a 4K x 32 memory
// - scratchpad pointer is a counter, matching the replacement choice
`timescale 1ns/1ps
`default_nettype none
module cam_scratchpad_cache (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire cam_pkg::instr_req_s instr_req,
   output logic instr_ready,
   output cam_pkg::lookup_rsp_s lookup_rsp,
   output cam_pkg::mem_req_s mem_req,
   input wire cam_pkg::mem_rsp_s mem_rsp,
   output cam_pkg::pad_wr_s pad_wr
);
   import cam_pkg::*;

   typedef enum logic [1:0] {IDLE, LOOKUP, FETCH, FILL} state_e;

   // sequencing: one lookup in flight at a time
   state_e state_q, state_d;
   logic [INSTR_W-1:0] instr_q, instr_d;
   logic ready_q, ready_d;
   // replacement pointer
   idx_t ptr_q, ptr_d;
   // slot and word held while the fill is pending
   idx_t fill_idx_q, fill_idx_d;
   logic [DATA_W-1:0] fill_data_q, fill_data_d;
   // registered answers towards cpu and memory
   lookup_rsp_s rsp_q, rsp_d;
   mem_req_s mreq_q, mreq_d;
   pad_wr_s pwr_q, pwr_d;

   tag_t lookup_tag;
   logic hit, full, tag_we;
   idx_t hit_idx, free_idx;
   logic take, miss, got_word;

   function automatic tag_t addr_field(input logic [INSTR_W-1:0] w);
      return w[ADDR_LSB +: TAG_W];
   endfunction

   // free slots first; once every latch is set the pointer decides
   function automatic idx_t pick_slot(
      input logic is_full,
      input idx_t rr,
      input idx_t fr
   );
      idx_t r;
      if (is_full) begin
         r = rr;
      end else begin
         r = fr;
      end
      return r;
   endfunction

   assign lookup_tag = addr_field(instr_q);
   assign tag_we = (state_q == FILL);
   assign take = (state_q == IDLE) && instr_req.valid && ready_q;
   assign miss = (state_q == LOOKUP) && !hit;
   // memory word seen while waiting; used by fill and answer groups
   assign got_word = (state_q == FETCH) && mem_rsp.valid;

   // tag store keeps the valid latches and does the parallel compare

   cam_tag_store u_tags (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .tag_in(lookup_tag),
      .wr_en(tag_we),
      .wr_idx(fill_idx_q),
      .hit(hit),
      .hit_idx(hit_idx),
      .full(full),
      .free_idx(free_idx)
   );

   // ready falls on take and comes back with the answer pulse
   always_comb begin
      state_d = state_q;
      instr_d = instr_q;
      ready_d = ready_q;
      case (state_q)
         IDLE: begin
            if (take) begin
               instr_d = instr_req.instr;
               ready_d = 1'b0;
               state_d = LOOKUP;
            end
         end
         LOOKUP: begin
            if (hit) begin
               ready_d = 1'b1;
               state_d = IDLE;
            end else begin
               state_d = FETCH;
            end
         end
         FETCH: begin
            if (mem_rsp.valid) begin
               state_d = FILL;
            end
         end
         FILL: begin
            // tag and valid written this edge, the same edge the answer goes out
            ready_d = 1'b1;
            state_d = IDLE;
         end
         default: begin
            state_d = IDLE;
            ready_d = 1'b1;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= IDLE;
         instr_q <= '0;
         ready_q <= 1'b1;
      end else begin
         state_q <= state_d;
         instr_q <= instr_d;
         ready_q <= ready_d;
      end
   end

   // slot chosen in the lookup cycle so the fill edge needs no search
   always_comb begin
      fill_idx_d = fill_idx_q;
      fill_data_d = fill_data_q;
      if (miss) begin
         fill_idx_d = pick_slot(full, ptr_q, free_idx);
      end
      if (got_word) begin
         fill_data_d = mem_rsp.data;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         fill_idx_q <= '0;
         fill_data_q <= '0;
      end else begin
         fill_idx_q <= fill_idx_d;
         fill_data_q <= fill_data_d;
      end
   end

   // a counter, not a shift register: round robin only ever steps by one
   always_comb begin
      ptr_d = ptr_q;
      // steps only after an overwrite; filling a free slot leaves it alone
      if (tag_we && full) begin
         ptr_d = ptr_q + 5'h01;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ptr_q <= PTR_RST;
      end else begin
         ptr_q <= ptr_d;
      end
   end

   // every output comes from a flop; lookup answers and pad writes are one-cycle pulses, the read is held
   always_comb begin
      rsp_d = '0;
      mreq_d = mreq_q;
      pwr_d = '0;
      if ((state_q == LOOKUP) && hit) begin
         rsp_d.valid = 1'b1;
         rsp_d.hit = 1'b1;
         rsp_d.index = hit_idx;
         rsp_d.instr = instr_q;
      end
      if (miss) begin
         mreq_d.req = 1'b1;
         mreq_d.addr = lookup_tag;
      end
      // read is held until the word arrives, then dropped
      if (got_word) begin
         mreq_d = '0;
      end
      if (tag_we) begin
         pwr_d.we = 1'b1;
         pwr_d.index = fill_idx_q;
         pwr_d.data = fill_data_q;
         rsp_d.valid = 1'b1;
         rsp_d.hit = 1'b0;
         rsp_d.index = fill_idx_q;
         rsp_d.instr = instr_q;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rsp_q <= '0;
         mreq_q <= '0;
         pwr_q <= '0;
      end else begin
         rsp_q <= rsp_d;
         mreq_q <= mreq_d;
         pwr_q <= pwr_d;
      end
   end

   assign instr_ready = ready_q;
   assign lookup_rsp = rsp_q;
   assign mem_req = mreq_q;
   assign pad_wr = pwr_q;
endmodule
`default_nettype wire

// [rtl/cam_tag_store.sv]
`timescale 1ns/1ps
`default_nettype none
module cam_tag_store (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire cam_pkg::tag_t tag_in,
   input wire logic wr_en,
   input wire cam_pkg::idx_t wr_idx,
   output logic hit,
   output cam_pkg::idx_t hit_idx,
   output logic full,
   output cam_pkg::idx_t free_idx
);
   import cam_pkg::*;

   tag_t tag_q [ENTRIES];
   tag_t tag_d [ENTRIES];
   logic [ENTRIES-1:0] valid_q, valid_d;
   logic [ENTRIES-1:0] match;

   // lowest set bit wins; used for both match and free search
   function automatic idx_t first_one(input logic [ENTRIES-1:0] v);
      idx_t r;
      r = '0;
      for (int i = ENTRIES - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = idx_t'(i);
         end
      end
      return r;
   endfunction

   always_comb begin
      for (int i = 0; i < ENTRIES; i++) begin
         match[i] = valid_q[i] && (tag_q[i] == tag_in);
      end
      hit = |match;
      hit_idx = first_one(match);
      full = &valid_q;
      free_idx = first_one(~valid_q);
   end

   always_comb begin
      tag_d = tag_q;
      valid_d = valid_q;
      if (wr_en) begin
         tag_d[wr_idx] = tag_in;
         valid_d[wr_idx] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         valid_q <= VALID_RST;
         for (int i = 0; i < ENTRIES; i++) begin
            tag_q[i] <= '0;
         end
      end else begin
         valid_q <= valid_d;
         tag_q <= tag_d;
      end
   end
endmodule
`default_nettype wire

// [sim/cam_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module cam_sva (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire cam_pkg::instr_req_s instr_req,
   input wire logic instr_ready,
   input wire cam_pkg::lookup_rsp_s lookup_rsp,
   input wire cam_pkg::mem_req_s mem_req,
   input wire cam_pkg::mem_rsp_s mem_rsp,
   input wire cam_pkg::pad_wr_s pad_wr
);
   import cam_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   logic tk;
   logic rd;
   assign tk = instr_req.valid && instr_ready;
   assign rd = mem_req.req && mem_rsp.valid;
   a_take_busy: assert property (tk |=> !instr_ready)
      else $error("ready after take");
   a_first_step: assert property (tk |-> ##2
      ((lookup_rsp.valid && lookup_rsp.hit) || mem_req.req))
      else $error("no lookup outcome");
   a_req_addr: assert property ($rose(mem_req.req) |->
      mem_req.addr == $past(instr_req.instr[11:0], 2))
      else $error("read address");
   a_req_hold: assert property (mem_req.req && !mem_rsp.valid |=>
      mem_req.req && $stable(mem_req.addr))
      else $error("read dropped");
   a_fill_step: assert property (rd |=> !mem_req.req ##1
      (pad_wr.we && lookup_rsp.valid && !lookup_rsp.hit))
      else $error("fill timing");
   a_fill_data: assert property (rd |-> ##2
      pad_wr.data == $past(mem_rsp.data, 2))
      else $error("fill data");
   a_fill_index: assert property (pad_wr.we |->
      lookup_rsp.valid && pad_wr.index == lookup_rsp.index)
      else $error("fill index");
   a_hit_no_read: assert property (lookup_rsp.valid && lookup_rsp.hit |->
      !mem_req.req && !pad_wr.we)
      else $error("hit with read");
   a_rsp_ready: assert property (lookup_rsp.valid |->
      instr_ready && $past(!instr_ready))
      else $error("ready at answer");
   c_hit: cover property (lookup_rsp.valid && lookup_rsp.hit);
   c_fill: cover property (pad_wr.we);
   c_read: cover property (rd);
endmodule
bind cam_scratchpad_cache cam_sva i_sva (.ref_clk(ref_clk),
   .arst_n(arst_n), .instr_req(instr_req), .instr_ready(instr_ready),
   .lookup_rsp(lookup_rsp), .mem_req(mem_req), .mem_rsp(mem_rsp),
   .pad_wr(pad_wr));
`default_nettype wire

// [sim/mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mem_model (
   input wire logic ref_clk,
   input wire logic [1:0] lat,
   input wire cam_pkg::mem_req_s mem_req,
   output cam_pkg::mem_rsp_s mem_rsp
);
   import cam_pkg::*;
   logic [1:0] cnt;
   initial mem_rsp = '0;
   initial cnt = 2'h0;
   always @(posedge ref_clk) begin
      mem_rsp.valid <= 1'b0;
      // idle data toggles so a stale word is never mistaken for a reply
      mem_rsp.data <= ~mem_rsp.data;
      cnt <= 2'h0;
      if (mem_req.req && !mem_rsp.valid) begin
         cnt <= cnt + 2'h1;
         if (cnt == lat) begin
            mem_rsp <= '{1'b1, {mem_req.addr, mem_req.addr, 8'h3c}};
         end
      end
   end
endmodule
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import cam_pkg::*;
   logic ref_clk, arst_n, instr_ready;
   logic [1:0] lat;
   instr_req_s instr_req;
   lookup_rsp_s lookup_rsp;
   mem_req_s mem_req;
   mem_rsp_s mem_rsp;
   pad_wr_s pad_wr;
   int n_mismatch, compares;
   cam_scratchpad_cache i_dut (.ref_clk(ref_clk), .arst_n(arst_n),
      .instr_req(instr_req), .instr_ready(instr_ready),
      .lookup_rsp(lookup_rsp), .mem_req(mem_req), .mem_rsp(mem_rsp),
      .pad_wr(pad_wr));
   mem_model i_mem (.ref_clk(ref_clk), .lat(lat), .mem_req(mem_req),
      .mem_rsp(mem_rsp));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic chk(input string s, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic complete_run;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // entered at a falling edge with the block idle
   task automatic look(input logic [11:0] a, input logic h, input idx_t x);
      int n;
      n = 0;
      instr_req <= '{1'b1, {20'h0, a}};
      @(negedge ref_clk);
      instr_req.valid <= 1'b0;
      while (!lookup_rsp.valid && n < 50) begin
         @(negedge ref_clk);
         n++;
      end
      chk("answer", 32'h1, {31'h0, lookup_rsp.valid});
      chk("hit", {31'h0, h}, {31'h0, lookup_rsp.hit});
      chk("index", {27'h0, x}, {27'h0, lookup_rsp.index});
      chk("we", {31'h0, !h}, {31'h0, pad_wr.we});
      chk("instr", {20'h0, a}, lookup_rsp.instr);
      if (!h) begin
         chk("fill", {a, a, 8'h3c}, pad_wr.data);
         chk("slot", {27'h0, x}, {27'h0, pad_wr.index});
      end
   endtask
   task automatic t_cold_miss;
      lat = 2'h2;
      look(12'h000, 1'b0, 5'h00);
   endtask
   task automatic t_fill;
      for (int i = 1; i < 32; i++) begin
         lat = 2'(i);
         look(12'(i * 7), 1'b0, 5'(i));
      end
   endtask
   task automatic t_hit;
      look(12'h007, 1'b1, 5'h01);
      look(12'h0d9, 1'b1, 5'h1f);
   endtask
   // full store: victims go round robin from entry 0
   task automatic t_victim;
      look(12'hfff, 1'b0, 5'h00);
      look(12'h000, 1'b0, 5'h01);
      look(12'hfff, 1'b1, 5'h00);
   endtask
   // mid-run reset: every tag latch clears, the next fill takes free entry 0
   task automatic t_reset;
      arst_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      arst_n = 1'b1;
      chk("reset ready", 32'h1, {31'h0, instr_ready});
      look(12'hfff, 1'b0, 5'h00);
      look(12'hfff, 1'b1, 5'h00);
   endtask
   initial begin
      instr_req = '0;
      lat = 2'h0;
      arst_n = 1'b0;
      n_mismatch = 0;
      compares = 0;
      repeat (6) @(negedge ref_clk);
      arst_n = 1'b1;
      chk("idle ready", 32'h1, {31'h0, instr_ready});
      t_cold_miss;
      t_fill;
      t_hit;
      t_victim;
      t_reset;
      complete_run;
   end
   initial begin
      #20000;
      n_mismatch++;
      complete_run;
   end
endmodule
`default_nettype wire
